// File: hw/energy_event_flag_unit.sv
// Event enable and flag registers of the power manager with the request pin.
// Assumes a serial-interface register port in front of it with single-cycle
// read and write strobes, and monitor outputs synchronous to clk_i.
`timescale 1ns/1ps
`include "energy_event_map.svh"
module energy_event_flag_unit
    import energy_event_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire reg_addr_t reg_addr_i,
    input wire logic reg_wr_i,
    input wire reg_data_t reg_wdata_i,
    input wire logic reg_rd_i,
    output reg_data_t reg_rdata_o,
    input wire logic discharge_cold_limit_i,
    input wire logic discharge_hot_limit_i,
    input wire logic charge_cold_limit_i,
    input wire logic charge_hot_limit_i,
    input wire logic source1_low_i,
    input wire logic source2_low_i,
    input wire logic overcharge_level_i,
    input wire logic charge_ready_level_i,
    input wire logic overdischarge_level_i,
    input wire logic interface_ready_i,
    input wire logic power_monitor_error_i,
    input wire logic power_monitor_data_i,
    input wire logic temp_conversion_done_i,
    input wire logic storage_conversion_done_i,
    input wire logic tracking_start_first_i,
    input wire logic tracking_done_first_i,
    input wire logic tracking_start_second_i,
    input wire logic tracking_done_second_i,
    output logic event_req_o
);
    function automatic logic reg_hit(input reg_addr_t addr, input reg_addr_t target);
        reg_hit = (addr == target);
    endfunction

    reg_data_t enable_lo_ff;
    reg_data_t enable_hi_ff;
    reg_data_t rdata_ff;
    logic event_req_ff;

    logic hit_enable_lo;
    logic hit_enable_hi;
    logic hit_flags_lo;
    logic hit_flags_hi;

    logic wr_enable_lo;
    logic wr_enable_hi;
    logic rd_enable_lo;
    logic rd_enable_hi;
    logic clr_flags_lo;
    logic clr_flags_hi;
    logic any_flag_lo;
    logic any_flag_hi;
    reg_data_t nxt_enable_lo;
    reg_data_t nxt_enable_hi;
    reg_data_t nxt_rdata;
    logic nxt_event_req;

    logic [8:0] level_vec;
    logic [8:0] cross_vec;
    logic [0:0] ready_pulse;
    logic [7:0] done_vec;
    logic [7:0] done_pulse;
    logic both_low;
    event_vec_t event_lo;
    event_vec_t event_hi;
    event_vec_t flags_lo;
    event_vec_t flags_hi;

    logic discharge_temp_event;
    logic charge_temp_event;
    logic sources_low_event;
    logic overcharge_event;
    logic charge_ready_event;
    logic overdischarge_event;
    logic interface_ready_event;
    logic power_monitor_error_event;
    logic power_monitor_data_event;
    logic temp_conversion_done_event;
    logic storage_conversion_done_event;
    logic tracking_done_second_event;
    logic tracking_start_second_event;
    logic tracking_done_first_event;
    logic tracking_start_first_event;

    assign hit_enable_lo = reg_hit(reg_addr_i, `EV_ENABLE_LO_ADDR);
    assign hit_enable_hi = reg_hit(reg_addr_i, `EV_ENABLE_HI_ADDR);
    assign hit_flags_lo = reg_hit(reg_addr_i, `EV_FLAGS_LO_ADDR);
    assign hit_flags_hi = reg_hit(reg_addr_i, `EV_FLAGS_HI_ADDR);
    // Strobes are decoded once and shared by the write, read and clear paths.
    assign wr_enable_lo = reg_wr_i & hit_enable_lo;
    assign wr_enable_hi = reg_wr_i & hit_enable_hi;
    assign rd_enable_lo = reg_rd_i & hit_enable_lo;
    assign rd_enable_hi = reg_rd_i & hit_enable_hi;
    assign clr_flags_lo = reg_rd_i & hit_flags_lo;
    assign clr_flags_hi = reg_rd_i & hit_flags_hi;

    // Monitor levels whose every change is a threshold crossing.
    assign both_low = source1_low_i & source2_low_i;
    assign level_vec = {discharge_cold_limit_i,
                        discharge_hot_limit_i,
                        charge_cold_limit_i,
                        charge_hot_limit_i,
                        both_low,
                        overcharge_level_i,
                        charge_ready_level_i,
                        overdischarge_level_i,
                        1'b0};

    event_crossing_detect #(
        .WIDTH(9),
        .BOTH_EDGES(1'b1)
    ) u_level_cross (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .level_i(level_vec),
        .pulse_o(cross_vec)
    );

    // Only the rising edge of interface readiness counts; losing the
    // interface later raises nothing.
    event_crossing_detect #(
        .WIDTH(1),
        .BOTH_EDGES(1'b0)
    ) u_ready_rise (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .level_i(interface_ready_i),
        .pulse_o(ready_pulse)
    );

    // Completion indications may be held for several cycles by their
    // sources; only the rising edge counts, so a long strobe sets one flag.
    assign done_vec = {power_monitor_error_i,
                       power_monitor_data_i,
                       temp_conversion_done_i,
                       storage_conversion_done_i,
                       tracking_done_second_i,
                       tracking_start_second_i,
                       tracking_done_first_i,
                       tracking_start_first_i};

    event_crossing_detect #(
        .WIDTH(8),
        .BOTH_EDGES(1'b0)
    ) u_done_rise (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .level_i(done_vec),
        .pulse_o(done_pulse)
    );

    // The source-low event fires only on the way into the both-low state,
    // not when the pair recovers.
    logic both_low_prev_ff;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            both_low_prev_ff <= 1'b1;
        end else begin
            both_low_prev_ff <= both_low;
        end
    end

    // Temperature and storage levels flag on either edge of their status.
    assign discharge_temp_event = cross_vec[8] | cross_vec[7];
    assign charge_temp_event = cross_vec[6] | cross_vec[5];
    assign sources_low_event = cross_vec[4] & both_low & ~both_low_prev_ff;
    assign overcharge_event = cross_vec[3];
    assign charge_ready_event = cross_vec[2];
    assign overdischarge_event = cross_vec[1];
    assign interface_ready_event = ready_pulse[0];
    assign power_monitor_error_event = done_pulse[7];
    assign power_monitor_data_event = done_pulse[6];
    assign temp_conversion_done_event = done_pulse[5];
    assign storage_conversion_done_event = done_pulse[4];
    assign tracking_done_second_event = done_pulse[3];
    assign tracking_start_second_event = done_pulse[2];
    assign tracking_done_first_event = done_pulse[1];
    assign tracking_start_first_event = done_pulse[0];

    assign event_lo[7] = 1'b0;
    assign event_lo[`EV_LO_DISCHARGE_TEMP] = discharge_temp_event;
    assign event_lo[`EV_LO_CHARGE_TEMP] = charge_temp_event;
    assign event_lo[`EV_LO_SOURCES_LOW] = sources_low_event;
    assign event_lo[`EV_LO_OVERCHARGE] = overcharge_event;
    assign event_lo[`EV_LO_CHARGE_READY] = charge_ready_event;
    assign event_lo[`EV_LO_OVERDISCHARGE] = overdischarge_event;
    assign event_lo[`EV_LO_INTERFACE_READY] = interface_ready_event;

    assign event_hi[`EV_HI_MONITOR_ERROR] = power_monitor_error_event;
    assign event_hi[`EV_HI_MONITOR_DATA] = power_monitor_data_event;
    assign event_hi[`EV_HI_TEMP_DONE] = temp_conversion_done_event;
    assign event_hi[`EV_HI_STORAGE_DONE] = storage_conversion_done_event;
    assign event_hi[`EV_HI_TRACK_DONE_SECOND] = tracking_done_second_event;
    assign event_hi[`EV_HI_TRACK_START_SECOND] = tracking_start_second_event;
    assign event_hi[`EV_HI_TRACK_DONE_FIRST] = tracking_done_first_event;
    assign event_hi[`EV_HI_TRACK_START_FIRST] = tracking_start_first_event;

    // Enables are only changed by register writes; leaving the serial
    // configuration mode does not touch them, so flags keep working.
    assign nxt_enable_lo = wr_enable_lo ?
                           (reg_wdata_i & `EV_LO_USED_MASK) : enable_lo_ff;
    assign nxt_enable_hi = wr_enable_hi ? reg_wdata_i : enable_hi_ff;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            enable_lo_ff <= `EV_ENABLE_LO_RST;
        end else begin
            enable_lo_ff <= nxt_enable_lo;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            enable_hi_ff <= `EV_ENABLE_HI_RST;
        end else begin
            enable_hi_ff <= nxt_enable_hi;
        end
    end

    event_flag_bank #(
        .RESET_VAL(`EV_FLAGS_LO_RST)
    ) u_flags_lo (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .event_i(event_lo),
        .enable_i(enable_lo_ff),
        .clear_i(clr_flags_lo),
        .flags_o(flags_lo)
    );

    event_flag_bank #(
        .RESET_VAL(`EV_FLAGS_HI_RST)
    ) u_flags_hi (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .event_i(event_hi),
        .enable_i(enable_hi_ff),
        .clear_i(clr_flags_hi),
        .flags_o(flags_hi)
    );

    // Read data are registered: they appear the cycle after the strobe and
    // hold until the next read. Unmapped offsets read as zero.
    assign nxt_rdata = rd_enable_lo ? enable_lo_ff :
                       rd_enable_hi ? enable_hi_ff :
                       clr_flags_lo ? flags_lo :
                       clr_flags_hi ? flags_hi :
                       reg_rd_i ? `EV_UNMAPPED_DATA :
                       rdata_ff;

    // The pin follows the flag registers one cycle late so that it comes
    // straight from a flip-flop; it therefore also drops one cycle after
    // the clearing read.
    assign any_flag_lo = |flags_lo;
    assign any_flag_hi = |flags_hi;
    assign nxt_event_req = any_flag_lo | any_flag_hi;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            event_req_ff <= 1'b1;
        end else begin
            event_req_ff <= nxt_event_req;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign event_req_o = event_req_ff;
endmodule

// File: hw/energy_event_map.svh
// Register offsets, field positions and reset values of the event flag unit.
// Included by the flag unit, its checker and the bench; holds definitions only.
`ifndef ENERGY_EVENT_MAP_SVH
`define ENERGY_EVENT_MAP_SVH

`define EV_ENABLE_LO_ADDR 8'h12
`define EV_ENABLE_HI_ADDR 8'h13
`define EV_FLAGS_LO_ADDR 8'h15
`define EV_FLAGS_HI_ADDR 8'h16

`define EV_ENABLE_LO_RST 8'h01
`define EV_ENABLE_HI_RST 8'h00
`define EV_FLAGS_LO_RST 8'h01
`define EV_FLAGS_HI_RST 8'h00
`define EV_LO_USED_MASK 8'h7F
`define EV_UNMAPPED_DATA 8'h00

`define EV_LO_DISCHARGE_TEMP 6
`define EV_LO_CHARGE_TEMP 5
`define EV_LO_SOURCES_LOW 4
`define EV_LO_OVERCHARGE 3
`define EV_LO_CHARGE_READY 2
`define EV_LO_OVERDISCHARGE 1
`define EV_LO_INTERFACE_READY 0

`define EV_HI_MONITOR_ERROR 7
`define EV_HI_MONITOR_DATA 6
`define EV_HI_TEMP_DONE 5
`define EV_HI_STORAGE_DONE 4
`define EV_HI_TRACK_DONE_SECOND 3
`define EV_HI_TRACK_START_SECOND 2
`define EV_HI_TRACK_DONE_FIRST 1
`define EV_HI_TRACK_START_FIRST 0

`endif

// File: hw/energy_event_pkg.sv
// Types shared by the event flag unit and its helpers.
// Assumes nothing of its surroundings.
package energy_event_pkg;
    typedef logic [7:0] reg_addr_t;
    typedef logic [7:0] reg_data_t;
    typedef logic [7:0] event_vec_t;
endpackage

// File: hw/event_crossing_detect.sv
// Turns monitor levels into one-cycle event pulses.
// Assumes the levels are synchronous to clk_i.
`timescale 1ns/1ps
module event_crossing_detect
    import energy_event_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter bit BOTH_EDGES = 1'b1
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] level_i,
    output logic [WIDTH-1:0] pulse_o
);
    logic [WIDTH-1:0] prev_ff;
    logic armed_ff;

    // The first sample after reset only primes the history, so a level that is
    // already set at release does not read as a crossing.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prev_ff <= '0;
            armed_ff <= 1'b0;
        end else begin
            prev_ff <= level_i;
            armed_ff <= 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            if (BOTH_EDGES) begin : g_both
                assign pulse_o[i] = armed_ff & (level_i[i] ^ prev_ff[i]);
            end else begin : g_rise
                assign pulse_o[i] = armed_ff & level_i[i] & ~prev_ff[i];
            end
        end
    endgenerate
endmodule

// File: hw/event_flag_bank.sv
// One byte of sticky event flags with enables and clear on read.
// Assumes event pulses and the clear strobe are synchronous to clk_i.
`timescale 1ns/1ps
module event_flag_bank
    import energy_event_pkg::*;
#(
    parameter event_vec_t RESET_VAL = 8'h00
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire event_vec_t event_i,
    input wire event_vec_t enable_i,
    input wire logic clear_i,
    output event_vec_t flags_o
);
    event_vec_t flags_ff;
    event_vec_t set_vec;
    event_vec_t kept_vec;
    event_vec_t nxt_flags;

    assign set_vec = event_i & enable_i;
    // A read clears exactly the value it returned; an event in the same cycle
    // still sets its bit, so nothing raised during the read is lost.
    assign kept_vec = clear_i ? 8'h00 : flags_ff;
    assign nxt_flags = kept_vec | set_vec;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_ff <= RESET_VAL;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags_o = flags_ff;
endmodule

// File: testbench/energy_event_flag_unit_chk.sv
// Assertions on the register port and request pin of the event flag unit.
// Assumes it is bound to energy_event_flag_unit and sees only its ports.
`timescale 1ns/1ps
`include "energy_event_map.svh"
module energy_event_flag_unit_chk
    import energy_event_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire reg_addr_t reg_addr_i,
    input wire logic reg_wr_i,
    input wire reg_data_t reg_wdata_i,
    input wire logic reg_rd_i,
    input wire reg_data_t reg_rdata_o,
    input wire logic event_req_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic flag_rd = reg_rd_i && (reg_addr_i == `EV_FLAGS_LO_ADDR ||
        reg_addr_i == `EV_FLAGS_HI_ADDR);
    wire logic wr_only = reg_wr_i && !reg_rd_i;
    wire logic rd_only = reg_rd_i && !reg_wr_i;
    property p_unmapped;
        reg_rd_i && reg_addr_i == 8'h40 |=> reg_rdata_o == `EV_UNMAPPED_DATA;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rdata_hold;
        !reg_rd_i |=> $stable(reg_rdata_o);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    // A fall needs a flag read exactly two edges back, since the pin is registered.
    property p_pin_fall;
        $fell(event_req_o) |-> $past(flag_rd, 2);
    endproperty
    a_pin_fall: assert property (p_pin_fall) else $error("pin fell without read");
    property p_pin_hold;
        event_req_o && !flag_rd && !$past(flag_rd) |=> event_req_o;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin dropped");
    property p_en_lo;
        wr_only && reg_addr_i == `EV_ENABLE_LO_ADDR ##1
        rd_only && reg_addr_i == `EV_ENABLE_LO_ADDR
        |=> reg_rdata_o == ($past(reg_wdata_i, 2) & `EV_LO_USED_MASK);
    endproperty
    a_en_lo: assert property (p_en_lo) else $error("low enable readback");
    property p_en_hi;
        wr_only && reg_addr_i == `EV_ENABLE_HI_ADDR ##1
        wr_only && reg_addr_i == `EV_FLAGS_LO_ADDR ##1
        rd_only && reg_addr_i == `EV_ENABLE_HI_ADDR |=> reg_rdata_o == $past(reg_wdata_i, 3);
    endproperty
    a_en_hi: assert property (p_en_hi) else $error("high enable readback");
    property p_en_reread;
        rd_only && reg_addr_i == `EV_ENABLE_LO_ADDR ##1
        rd_only && reg_addr_i == `EV_ENABLE_LO_ADDR |=> $stable(reg_rdata_o);
    endproperty
    a_en_reread: assert property (p_en_reread) else $error("enable read changed");
    property p_wr_rd_same;
        reg_wr_i && reg_rd_i && reg_addr_i == `EV_ENABLE_HI_ADDR ##1
        rd_only && reg_addr_i == `EV_ENABLE_HI_ADDR |=> reg_rdata_o == $past(reg_wdata_i, 2);
    endproperty
    a_wr_rd_same: assert property (p_wr_rd_same) else $error("same-cycle write lost");
    c_flag_read: cover property (flag_rd && event_req_o);
    c_pin_fell: cover property ($fell(event_req_o));
    c_pin_rose: cover property ($rose(event_req_o));
endmodule
bind energy_event_flag_unit energy_event_flag_unit_chk u_chk (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .event_req_o(event_req_o));

// File: testbench/host_model.sv
// Host model that reaches the flag unit registers with single-cycle strobes.
// Assumes strobes are taken at the rising edge and read data is registered.
`timescale 1ns/1ps
module host_model
    import energy_event_pkg::*;
(
    input wire logic clk_i,
    input wire reg_data_t rdata_i,
    output reg_addr_t addr_o,
    output logic wr_o,
    output reg_data_t wdata_o,
    output logic rd_o
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Called at a falling edge; strobes stay up after return until idle() or the next call re-drives them.
    task automatic xfer(input logic w, input logic r, input reg_addr_t a,
                        input reg_data_t d, output reg_data_t q);
        addr_o = a;
        wdata_o = d;
        wr_o = w;
        rd_o = r;
        @(posedge clk_i);
        @(negedge clk_i);
        q = rdata_i;
    endtask
    task automatic idle();
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
    endtask
endmodule

// File: testbench/tb_energy_event_flag_unit.sv
// Self-checking bench of the event flag unit against an integer model.
// Assumes host_model drives the register port and the bound checker.
`timescale 1ns/1ps
`include "energy_event_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_energy_event_flag_unit import energy_event_pkg::*;;
    logic clk_i, sys_rst_i, reg_wr, reg_rd, event_req;
    reg_addr_t reg_addr;
    reg_data_t reg_wdata, rdata, q, d;
    logic [17:0] lv, n;
    int errors, n_checks, en_lo, en_hi, fl_lo, fl_hi;
    host_model u_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(reg_addr), .wr_o(reg_wr),
        .wdata_o(reg_wdata), .rd_o(reg_rd));
    energy_event_flag_unit DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
        .discharge_cold_limit_i(lv[0]), .discharge_hot_limit_i(lv[1]),
        .charge_cold_limit_i(lv[2]), .charge_hot_limit_i(lv[3]),
        .source1_low_i(lv[4]), .source2_low_i(lv[5]), .overcharge_level_i(lv[6]),
        .charge_ready_level_i(lv[7]), .overdischarge_level_i(lv[8]),
        .interface_ready_i(lv[9]), .power_monitor_error_i(lv[10]),
        .power_monitor_data_i(lv[11]), .temp_conversion_done_i(lv[12]),
        .storage_conversion_done_i(lv[13]), .tracking_done_second_i(lv[14]),
        .tracking_start_second_i(lv[15]), .tracking_done_first_i(lv[16]),
        .tracking_start_first_i(lv[17]), .event_req_o(event_req));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic rd(input reg_addr_t a);
        u_host.xfer(1'b0, 1'b1, a, 8'h00, q);
    endtask
    task automatic wr(input reg_addr_t a, input reg_data_t v);
        u_host.xfer(1'b1, 1'b0, a, v, q);
        if (a == `EV_ENABLE_LO_ADDR) en_lo = v & 8'h7F;
        if (a == `EV_ENABLE_HI_ADDR) en_hi = v;
    endtask
    task automatic rd_flags();
        rd(`EV_FLAGS_LO_ADDR);
        `CHK(q, fl_lo[7:0])
        fl_lo = 0;
        rd(`EV_FLAGS_HI_ADDR);
        `CHK(q, fl_hi[7:0])
        fl_hi = 0;
    endtask
    // Temperature and storage levels flag on either edge, both sources low on entry only, the rest on rising edges only.
    task automatic apply(input logic [17:0] v);
        logic [7:0] lo, hi;
        lo[6] = |(lv[1:0] ^ v[1:0]);
        lo[5] = |(lv[3:2] ^ v[3:2]);
        lo[4] = &v[5:4] && !(&lv[5:4]);
        lo[7] = 1'b0;
        lo[3] = lv[6] ^ v[6];
        lo[2] = lv[7] ^ v[7];
        lo[1] = lv[8] ^ v[8];
        lo[0] = v[9] && !lv[9];
        for (int i = 0; i < 8; i++) hi[7-i] = v[10+i] && !lv[10+i];
        fl_lo |= lo & en_lo;
        fl_hi |= hi & en_hi;
        lv = v;
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        results();
    end
    initial begin
        void'($urandom(32'h9ED21E3D));
        sys_rst_i = 1'b1;
        lv = 18'h0;
        {errors, n_checks, en_lo, en_hi, fl_lo, fl_hi} = {32'd0, 32'd0, 32'd1, 96'd0};
        fl_lo = 1;
        repeat (4) @(negedge clk_i);
        sys_rst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        `CHK(event_req, 1'b1)
        rd(`EV_ENABLE_LO_ADDR);
        `CHK(q, 8'h01)
        rd(`EV_ENABLE_HI_ADDR);
        `CHK(q, 8'h00)
        rd(8'h40);
        `CHK(q, 8'h00)
        rd_flags();
        u_host.idle();
        `CHK(event_req, 1'b0)
        @(negedge clk_i);
        wr(`EV_ENABLE_LO_ADDR, 8'hFF);
        rd(`EV_ENABLE_LO_ADDR);
        `CHK(q, 8'h7F)
        rd(`EV_ENABLE_LO_ADDR);
        `CHK(q, 8'h7F)
        wr(`EV_ENABLE_HI_ADDR, 8'hA5);
        wr(`EV_FLAGS_LO_ADDR, 8'hFF);
        rd(`EV_ENABLE_HI_ADDR);
        `CHK(q, 8'hA5)
        u_host.xfer(1'b1, 1'b1, `EV_ENABLE_HI_ADDR, 8'h5A, q);
        `CHK(q, 8'hA5)
        en_hi = 8'h5A;
        rd(`EV_ENABLE_HI_ADDR);
        `CHK(q, 8'h5A)
        rd(`EV_FLAGS_LO_ADDR);
        `CHK(q, 8'h00)
        for (int i = 0; i < 48; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            wr(`EV_ENABLE_LO_ADDR, d);
            wr(`EV_ENABLE_HI_ADDR, (i < 2) ? d : 8'($urandom));
            u_host.idle();
            n = 18'($urandom);
            apply(n);
            repeat (2) @(negedge clk_i);
            `CHK(event_req, (fl_lo | fl_hi) != 0)
            rd_flags();
        end
        // A flag read that meets a new event returns the old byte and keeps the new bit.
        wr(`EV_ENABLE_HI_ADDR, 8'hFF);
        u_host.idle();
        apply(lv & 18'h1FFFF);
        @(negedge clk_i);
        d = fl_hi[7:0];
        apply(lv | 18'h20000);
        rd(`EV_FLAGS_HI_ADDR);
        `CHK(q, d)
        rd(`EV_FLAGS_HI_ADDR);
        `CHK(q, fl_hi[7:0])
        fl_hi = 0;
        results();
    end
endmodule
